// File: rca_pkg.sv
// constants for the calibration access and timestamp register bank
package rca_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_CLKOUT_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_OFFSET      = 8'h12;
  localparam logic [7:0] ADDR_OSC_CONFIG  = 8'h13;
  localparam logic [7:0] ADDR_ACCESS_CTRL = 8'h14;
  localparam logic [7:0] ADDR_STAMP_SEC   = 8'h15;
  localparam logic [7:0] ADDR_STAMP_MIN   = 8'h16;
  localparam logic [7:0] ADDR_STAMP_HOUR  = 8'h17;
  localparam logic [7:0] ADDR_STAMP_WDAY  = 8'h18;
  localparam logic [7:0] ADDR_STAMP_MDAY  = 8'h19;
  localparam logic [7:0] ADDR_STAMP_MON   = 8'h1a;

  // calendar addresses whose write triggers a capture
  localparam logic [7:0] ADDR_CAL_SEC     = 8'h00;
  localparam logic [7:0] ADDR_CAL_MIN     = 8'h02;
  localparam logic [7:0] ADDR_CAL_HOUR    = 8'h04;
  localparam logic [7:0] ADDR_CAL_LO      = 8'h06;
  localparam logic [7:0] ADDR_CAL_HI      = 8'h09;

  // ==========================================================
  // oscillator configuration fields
  localparam int OSC_POL_BIT    = 7;
  localparam int OSC_RATE_BIT   = 6;
  localparam int OSC_JIT_BIT    = 4;
  localparam int OSC_DRV_HI     = 3;
  localparam int OSC_DRV_LO     = 2;
  localparam int OSC_CAP_HI     = 1;
  localparam int OSC_CAP_LO     = 0;
  localparam logic [7:0] OSC_WRITE_MASK = 8'hdf;
  localparam logic [7:0] OSC_RESET      = 8'h02;

  // access control fields
  localparam int ACC_OWNER_BIT = 7;
  localparam logic [7:0] ACC_WRITE_MASK = 8'h80;
  localparam logic [7:0] ACC_RESET      = 8'h00;

  // clock-output control: divider select position
  localparam int CKO_DIV_HI = 1;
  localparam int CKO_DIV_LO = 0;
  localparam logic [7:0] CKO_RESET    = 8'h00;
  localparam logic [7:0] OFFSET_RESET = 8'h00;

  // ==========================================================
  // field encodings
  localparam logic [1:0] CAP_7P0  = 2'h0;
  localparam logic [1:0] CAP_6P0  = 2'h1;
  localparam logic [1:0] CAP_12P5 = 2'h2;
  localparam logic [1:0] DRV_NORMAL = 2'h0;
  localparam logic [1:0] DRV_LOW    = 2'h1;

  typedef enum logic [1:0] {
    RCA_DRIVE_NORMAL,
    RCA_DRIVE_LOW,
    RCA_DRIVE_HIGH
  } rca_drive_t;

  typedef enum logic [1:0] {
    RCA_CAP_7P0,
    RCA_CAP_6P0,
    RCA_CAP_12P5,
    RCA_CAP_UNDEF
  } rca_cap_t;

  // ==========================================================
  // correction rate: step sizes in 0.1 ppb units, periods
  localparam int STEP_NORMAL_X10PPB = 21700;
  localparam int STEP_FAST_X10PPB   = 20345;
  localparam int PERIOD_NORMAL_HOURS = 4;
  localparam int PERIOD_FAST_MINUTES = 8;
  localparam int REWRITE_WAIT_MS     = 135;

  // timestamp reset values
  localparam logic [7:0] STAMP_SEC_RESET  = 8'h00;
  localparam logic [7:0] STAMP_MIN_RESET  = 8'h00;
  localparam logic [7:0] STAMP_HOUR_RESET = 8'h12;
  localparam logic [7:0] STAMP_WDAY_RESET = 8'h07;
  localparam logic [7:0] STAMP_MDAY_RESET = 8'h01;
  localparam logic [7:0] STAMP_MON_RESET  = 8'h01;

endpackage : rca_pkg

// File: rca_stamp_capture.sv
// timestamp registers copied from the calendar on a capture pulse
`timescale 1ns/1ps
`default_nettype none
module rca_stamp_capture (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       capture,
  input  wire logic [7:0] cal_sec,
  input  wire logic [7:0] cal_min,
  input  wire logic [7:0] cal_hour,
  input  wire logic [7:0] cal_wday,
  input  wire logic [7:0] cal_mday,
  input  wire logic [7:0] cal_mon,
  output var  logic [7:0] stamp_sec_q,
  output var  logic [7:0] stamp_min_q,
  output var  logic [7:0] stamp_hour_q,
  output var  logic [7:0] stamp_wday_q,
  output var  logic [7:0] stamp_mday_q,
  output var  logic [7:0] stamp_mon_q
);

  logic [7:0] stamp_sec_d;
  logic [7:0] stamp_min_d;
  logic [7:0] stamp_hour_d;
  logic [7:0] stamp_wday_d;
  logic [7:0] stamp_mday_d;
  logic [7:0] stamp_mon_d;

  // ==========================================================
  // capture
  always_comb begin
    stamp_sec_d  = stamp_sec_q;
    stamp_min_d  = stamp_min_q;
    stamp_hour_d = stamp_hour_q;
    stamp_wday_d = stamp_wday_q;
    stamp_mday_d = stamp_mday_q;
    stamp_mon_d  = stamp_mon_q;
    if (capture) begin
      stamp_sec_d  = cal_sec;
      stamp_min_d  = cal_min;
      stamp_hour_d = cal_hour;
      stamp_wday_d = cal_wday;
      stamp_mday_d = cal_mday;
      stamp_mon_d  = cal_mon;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stamp_sec_q  <= rca_pkg::STAMP_SEC_RESET;
      stamp_min_q  <= rca_pkg::STAMP_MIN_RESET;
      stamp_hour_q <= rca_pkg::STAMP_HOUR_RESET;
      stamp_wday_q <= rca_pkg::STAMP_WDAY_RESET;
      stamp_mday_q <= rca_pkg::STAMP_MDAY_RESET;
      stamp_mon_q  <= rca_pkg::STAMP_MON_RESET;
    end else begin
      stamp_sec_q  <= stamp_sec_d;
      stamp_min_q  <= stamp_min_d;
      stamp_hour_q <= stamp_hour_d;
      stamp_wday_q <= stamp_wday_d;
      stamp_mday_q <= stamp_mday_d;
      stamp_mon_q  <= stamp_mon_d;
    end
  end

endmodule : rca_stamp_capture
`default_nettype wire

// File: rca_calib_bank.sv
// calibration registers, port ownership and timestamp capture of the clock
`timescale 1ns/1ps
`default_nettype none
module rca_calib_bank (
  input  wire logic               clk,
  input  wire logic               resetn,
  // primary port register access
  input  wire logic               pri_wr_en,
  input  wire logic               pri_rd_en,
  input  wire logic [7:0]         pri_addr,
  input  wire logic [7:0]         pri_wdata,
  output var  logic [7:0]         pri_rdata_q,
  output var  logic               pri_rvalid_q,
  // secondary port register access
  input  wire logic               sec_wr_en,
  input  wire logic               sec_rd_en,
  input  wire logic [7:0]         sec_addr,
  input  wire logic [7:0]         sec_wdata,
  output var  logic [7:0]         sec_rdata_q,
  output var  logic               sec_rvalid_q,
  // live calendar contents
  input  wire logic [7:0]         cal_sec,
  input  wire logic [7:0]         cal_min,
  input  wire logic [7:0]         cal_hour,
  input  wire logic [7:0]         cal_wday,
  input  wire logic [7:0]         cal_mday,
  input  wire logic [7:0]         cal_mon,
  // divided clock from the output divider
  input  wire logic               div_clk_raw,
  // configuration outputs
  output var  logic               clk_out_q,
  output var  logic               jitter_on_rising_q,
  output var  logic               jitter_on_falling_q,
  output var  logic [1:0]         output_divider_select_q,
  output var  logic               trim_rate_select_q,
  output var  logic               low_jitter_select_q,
  output var  logic [1:0]         crystal_drive_level_q,
  output var  logic [1:0]         load_cap_select_q,
  output var  rca_pkg::rca_drive_t drive_mode_q,
  output var  rca_pkg::rca_cap_t   cap_mode_q,
  output var  logic signed [7:0]  trim_value_q,
  output var  logic signed [23:0] trim_x10ppb_q,
  output var  logic               calib_owner_primary_q,
  output var  logic               calib_wr_pulse_q
);

  // ==========================================================
  // helpers
  function automatic logic is_cal_addr(input logic [7:0] a);
    is_cal_addr = (a == rca_pkg::ADDR_CAL_SEC) || (a == rca_pkg::ADDR_CAL_MIN) ||
                  (a == rca_pkg::ADDR_CAL_HOUR) ||
                  ((a >= rca_pkg::ADDR_CAL_LO) && (a <= rca_pkg::ADDR_CAL_HI));
  endfunction : is_cal_addr

  function automatic logic is_calib_addr(input logic [7:0] a);
    is_calib_addr = (a == rca_pkg::ADDR_CLKOUT_CTRL) || (a == rca_pkg::ADDR_OFFSET) ||
                    (a == rca_pkg::ADDR_OSC_CONFIG);
  endfunction : is_calib_addr

  logic [7:0] cko_q;
  logic [7:0] cko_d;
  logic [7:0] offset_q;
  logic [7:0] offset_d;
  logic [7:0] osc_q;
  logic [7:0] osc_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic       owner;
  logic       pri_calib_ok;
  logic       sec_calib_ok;
  logic [7:0] calib_wdata;
  logic       calib_wr;
  logic [7:0] calib_waddr;
  logic       capture_q;
  logic       capture_d;
  logic [7:0] stamp_sec;
  logic [7:0] stamp_min;
  logic [7:0] stamp_hour;
  logic [7:0] stamp_wday;
  logic [7:0] stamp_mday;
  logic [7:0] stamp_mon;

  assign owner = acc_q[rca_pkg::ACC_OWNER_BIT];

  // ==========================================================
  // write ownership
  always_comb begin
    pri_calib_ok = pri_wr_en && is_calib_addr(pri_addr) && owner;
    sec_calib_ok = sec_wr_en && is_calib_addr(sec_addr) && !owner;
    calib_wr     = pri_calib_ok || sec_calib_ok;
    calib_waddr  = pri_calib_ok ? pri_addr : sec_addr;
    calib_wdata  = pri_calib_ok ? pri_wdata : sec_wdata;
  end

  // ==========================================================
  // register file
  always_comb begin
    cko_d    = cko_q;
    offset_d = offset_q;
    osc_d    = osc_q;
    acc_d    = acc_q;
    // refused writes simply fall through with the old value
    if (calib_wr) begin
      case (calib_waddr)
        rca_pkg::ADDR_CLKOUT_CTRL: cko_d = calib_wdata;
        rca_pkg::ADDR_OFFSET:      offset_d = calib_wdata;
        rca_pkg::ADDR_OSC_CONFIG:  osc_d = calib_wdata & rca_pkg::OSC_WRITE_MASK;
        default:                   cko_d = cko_q;
      endcase
    end
    if (pri_wr_en && (pri_addr == rca_pkg::ADDR_ACCESS_CTRL)) begin
      acc_d = pri_wdata & rca_pkg::ACC_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cko_q    <= rca_pkg::CKO_RESET;
      offset_q <= rca_pkg::OFFSET_RESET;
      osc_q    <= rca_pkg::OSC_RESET;
      acc_q    <= rca_pkg::ACC_RESET;
    end else begin
      cko_q    <= cko_d;
      offset_q <= offset_d;
      osc_q    <= osc_d;
      acc_q    <= acc_d;
    end
  end

  // ==========================================================
  // timestamp capture: one cycle after the write so the calendar has taken it
  always_comb begin
    capture_d = (pri_wr_en && is_cal_addr(pri_addr)) || (sec_wr_en && is_cal_addr(sec_addr));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      capture_q <= 1'b0;
    end else begin
      capture_q <= capture_d;
    end
  end

  rca_stamp_capture u_stamp (
    .clk          (clk),
    .resetn       (resetn),
    .capture      (capture_q),
    .cal_sec      (cal_sec),
    .cal_min      (cal_min),
    .cal_hour     (cal_hour),
    .cal_wday     (cal_wday),
    .cal_mday     (cal_mday),
    .cal_mon      (cal_mon),
    .stamp_sec_q  (stamp_sec),
    .stamp_min_q  (stamp_min),
    .stamp_hour_q (stamp_hour),
    .stamp_wday_q (stamp_wday),
    .stamp_mday_q (stamp_mday),
    .stamp_mon_q  (stamp_mon)
  );

  // ==========================================================
  // read path, both ports see the same map
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      rca_pkg::ADDR_CLKOUT_CTRL: read_mux = cko_q;
      rca_pkg::ADDR_OFFSET:      read_mux = offset_q;
      rca_pkg::ADDR_OSC_CONFIG:  read_mux = osc_q;
      rca_pkg::ADDR_ACCESS_CTRL: read_mux = acc_q;
      rca_pkg::ADDR_STAMP_SEC:   read_mux = stamp_sec;
      rca_pkg::ADDR_STAMP_MIN:   read_mux = stamp_min;
      rca_pkg::ADDR_STAMP_HOUR:  read_mux = stamp_hour;
      rca_pkg::ADDR_STAMP_WDAY:  read_mux = stamp_wday;
      rca_pkg::ADDR_STAMP_MDAY:  read_mux = stamp_mday;
      rca_pkg::ADDR_STAMP_MON:   read_mux = stamp_mon;
      default:                   read_mux = 8'h00;
    endcase
  endfunction : read_mux

  logic [7:0] pri_rdata_d;
  logic [7:0] sec_rdata_d;

  always_comb begin
    pri_rdata_d = pri_rd_en ? read_mux(pri_addr) : pri_rdata_q;
    sec_rdata_d = sec_rd_en ? read_mux(sec_addr) : sec_rdata_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pri_rdata_q  <= 8'h00;
      pri_rvalid_q <= 1'b0;
      sec_rdata_q  <= 8'h00;
      sec_rvalid_q <= 1'b0;
    end else begin
      pri_rdata_q  <= pri_rdata_d;
      pri_rvalid_q <= pri_rd_en;
      sec_rdata_q  <= sec_rdata_d;
      sec_rvalid_q <= sec_rd_en;
    end
  end

  // ==========================================================
  // decoded configuration outputs
  logic                clk_out_d;
  logic                pol;
  rca_pkg::rca_drive_t drive_d;
  rca_pkg::rca_cap_t   cap_d;
  logic signed [23:0]  step_x10ppb;
  logic signed [31:0]  trim_prod;
  logic                calib_wr_pulse_d;
  logic                jitter_on_rising_d;
  logic                jitter_on_falling_d;
  logic [1:0]          output_divider_select_d;
  logic                trim_rate_select_d;
  logic                low_jitter_select_d;
  logic [1:0]          crystal_drive_level_d;
  logic [1:0]          load_cap_select_d;
  logic signed [7:0]   trim_value_d;
  logic signed [23:0]  trim_x10ppb_d;
  logic                calib_owner_primary_d;

  always_comb begin
    pol       = osc_q[rca_pkg::OSC_POL_BIT];
    clk_out_d = div_clk_raw ^ pol;
    case (osc_q[rca_pkg::OSC_DRV_HI:rca_pkg::OSC_DRV_LO])
      rca_pkg::DRV_NORMAL: drive_d = rca_pkg::RCA_DRIVE_NORMAL;
      rca_pkg::DRV_LOW:    drive_d = rca_pkg::RCA_DRIVE_LOW;
      default:             drive_d = rca_pkg::RCA_DRIVE_HIGH;
    endcase
    case (osc_q[rca_pkg::OSC_CAP_HI:rca_pkg::OSC_CAP_LO])
      rca_pkg::CAP_7P0:  cap_d = rca_pkg::RCA_CAP_7P0;
      rca_pkg::CAP_6P0:  cap_d = rca_pkg::RCA_CAP_6P0;
      rca_pkg::CAP_12P5: cap_d = rca_pkg::RCA_CAP_12P5;
      default:           cap_d = rca_pkg::RCA_CAP_UNDEF;
    endcase
    step_x10ppb = osc_q[rca_pkg::OSC_RATE_BIT] ? 24'(rca_pkg::STEP_FAST_X10PPB)
                                               : 24'(rca_pkg::STEP_NORMAL_X10PPB);
    trim_prod   = $signed(offset_q) * step_x10ppb;
    calib_wr_pulse_d = calib_wr && ((calib_waddr == rca_pkg::ADDR_OFFSET) ||
                                    (calib_waddr == rca_pkg::ADDR_OSC_CONFIG));
    jitter_on_rising_d      = osc_q[rca_pkg::OSC_JIT_BIT] && !pol;
    jitter_on_falling_d     = osc_q[rca_pkg::OSC_JIT_BIT] && pol;
    output_divider_select_d = cko_q[rca_pkg::CKO_DIV_HI:rca_pkg::CKO_DIV_LO];
    trim_rate_select_d      = osc_q[rca_pkg::OSC_RATE_BIT];
    low_jitter_select_d     = osc_q[rca_pkg::OSC_JIT_BIT];
    crystal_drive_level_d   = osc_q[rca_pkg::OSC_DRV_HI:rca_pkg::OSC_DRV_LO];
    load_cap_select_d       = osc_q[rca_pkg::OSC_CAP_HI:rca_pkg::OSC_CAP_LO];
    trim_value_d            = $signed(offset_q);
    trim_x10ppb_d           = trim_prod[23:0];
    calib_owner_primary_d   = owner;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_out_q               <= 1'b0;
      jitter_on_rising_q      <= 1'b0;
      jitter_on_falling_q     <= 1'b0;
      output_divider_select_q <= 2'h0;
      trim_rate_select_q      <= 1'b0;
      low_jitter_select_q     <= 1'b0;
      crystal_drive_level_q   <= 2'h0;
      load_cap_select_q       <= rca_pkg::CAP_12P5;
      drive_mode_q            <= rca_pkg::RCA_DRIVE_NORMAL;
      cap_mode_q              <= rca_pkg::RCA_CAP_12P5;
      trim_value_q            <= 8'sh00;
      trim_x10ppb_q           <= 24'sh000000;
      calib_owner_primary_q   <= 1'b0;
      calib_wr_pulse_q        <= 1'b0;
    end else begin
      clk_out_q               <= clk_out_d;
      jitter_on_rising_q      <= jitter_on_rising_d;
      jitter_on_falling_q     <= jitter_on_falling_d;
      output_divider_select_q <= output_divider_select_d;
      trim_rate_select_q      <= trim_rate_select_d;
      low_jitter_select_q     <= low_jitter_select_d;
      crystal_drive_level_q   <= crystal_drive_level_d;
      load_cap_select_q       <= load_cap_select_d;
      drive_mode_q            <= drive_d;
      cap_mode_q              <= cap_d;
      trim_value_q            <= trim_value_d;
      trim_x10ppb_q           <= trim_x10ppb_d;
      calib_owner_primary_q   <= calib_owner_primary_d;
      // marks the start of the host's rewrite wait
      calib_wr_pulse_q        <= calib_wr_pulse_d;
    end
  end

endmodule : rca_calib_bank
`default_nettype wire

// File: rca_calib_bank_monitor.sv
// concurrent checks on the ports of the calibration access bank
`timescale 1ns/1ps
`default_nettype none
module rca_calib_bank_monitor (
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic               pri_wr_en,
  input wire logic [7:0]         pri_addr,
  input wire logic [7:0]         pri_wdata,
  input wire logic               sec_wr_en,
  input wire logic [7:0]         sec_addr,
  input wire logic [7:0]         sec_wdata,
  input wire logic               div_clk_raw,
  input wire logic               clk_out_q,
  input wire logic               jitter_on_rising_q,
  input wire logic               jitter_on_falling_q,
  input wire logic               trim_rate_select_q,
  input wire logic               low_jitter_select_q,
  input wire logic [1:0]         crystal_drive_level_q,
  input wire logic [1:0]         load_cap_select_q,
  input wire rca_pkg::rca_drive_t drive_mode_q,
  input wire logic signed [7:0]  trim_value_q,
  input wire logic signed [23:0] trim_x10ppb_q,
  input wire logic               calib_owner_primary_q,
  input wire logic               calib_wr_pulse_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ==========================================================
  // ownership
  property p_owner_write;
    (pri_wr_en && pri_addr == 8'h14) |-> ##2 (calib_owner_primary_q == $past(pri_wdata[7], 2));
  endproperty
  a_owner_write: assert property (p_owner_write) else $error("owner bit not taken from primary");
  property p_owner_source;
    $changed(calib_owner_primary_q) |-> $past(pri_wr_en && pri_addr == 8'h14, 2);
  endproperty
  a_owner_source: assert property (p_owner_source) else $error("owner bit moved without primary write");
  property p_pri_osc;
    (pri_wr_en && pri_addr == 8'h13) ##1 calib_owner_primary_q |-> ##1 (low_jitter_select_q == $past(pri_wdata[4], 2));
  endproperty
  a_pri_osc: assert property (p_pri_osc) else $error("owner primary write lost");
  property p_sec_osc;
    (sec_wr_en && sec_addr == 8'h13) ##1 !calib_owner_primary_q |-> ##1 (trim_rate_select_q == $past(sec_wdata[6], 2));
  endproperty
  a_sec_osc: assert property (p_sec_osc) else $error("owner secondary write lost");
  property p_refuse;
    $changed(load_cap_select_q) |-> ($past(pri_wr_en && pri_addr == 8'h13, 2) && $past(calib_owner_primary_q))
      || ($past(sec_wr_en && sec_addr == 8'h13, 2) && !$past(calib_owner_primary_q));
  endproperty
  a_refuse: assert property (p_refuse) else $error("oscillator byte changed by non-owner");

  // ==========================================================
  // output clock and decodes
  property p_clk_inv;
    jitter_on_falling_q |-> (clk_out_q == !$past(div_clk_raw));
  endproperty
  a_clk_inv: assert property (p_clk_inv) else $error("clock not inverted");
  property p_clk_pass;
    jitter_on_rising_q |-> (clk_out_q == $past(div_clk_raw));
  endproperty
  a_clk_pass: assert property (p_clk_pass) else $error("clock inverted");
  property p_jit;
    ((jitter_on_rising_q || jitter_on_falling_q) == low_jitter_select_q) && !(jitter_on_rising_q && jitter_on_falling_q);
  endproperty
  a_jit: assert property (p_jit) else $error("jitter edge decode wrong");
  property p_drive;
    drive_mode_q == (crystal_drive_level_q == 2'h0 ? rca_pkg::RCA_DRIVE_NORMAL :
      crystal_drive_level_q == 2'h1 ? rca_pkg::RCA_DRIVE_LOW : rca_pkg::RCA_DRIVE_HIGH);
  endproperty
  a_drive: assert property (p_drive) else $error("drive decode wrong");
  property p_trim;
    trim_x10ppb_q == 24'(trim_value_q * (trim_rate_select_q ? 20345 : 21700));
  endproperty
  a_trim: assert property (p_trim) else $error("trim step scaling wrong");
  property p_wr_pulse;
    calib_wr_pulse_q |-> $past((pri_wr_en && (pri_addr == 8'h12 || pri_addr == 8'h13)) ||
      (sec_wr_en && (sec_addr == 8'h12 || sec_addr == 8'h13)));
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("rewrite mark without offset write");
  property p_wr_mark;
    ($changed(trim_value_q) || $changed(trim_rate_select_q)) |-> $past(calib_wr_pulse_q);
  endproperty
  a_wr_mark: assert property (p_wr_mark) else $error("trim change without rewrite mark");
endmodule : rca_calib_bank_monitor

bind rca_calib_bank rca_calib_bank_monitor rca_calib_bank_monitor_inst (.*);
`default_nettype wire

// File: rca_host_model.sv
// register-port host standing in for one bus controller
`timescale 1ns/1ps
`default_nettype none
module rca_host_model #(
  parameter int REWRITE_GAP = 4
) (
  input  wire logic       clk,
  output var  logic       wr_en,
  output var  logic       rd_en,
  output var  logic [7:0] addr,
  output var  logic [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end

  // ==========================================================
  // bus cycles; released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
    if (a == 8'h12 || a == 8'h13) begin
      repeat (REWRITE_GAP) @(posedge clk);
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    addr  <= ~a;
    ok = 1'b0;
    d  = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (rvalid === 1'b1) begin
        ok = 1'b1;
        d  = rdata;
      end
    end
  endtask : rd
endmodule : rca_host_model
`default_nettype wire

// File: test_rtc_calib_access_timestamp.sv
// self-checking bench for the calibration access and timestamp bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_rtc_calib_access_timestamp;
  logic                clk = 1'b0;
  logic                resetn = 1'b0;
  logic                div_clk_raw = 1'b0;
  logic [7:0]          cal [6] = '{default: 8'h00};
  logic                pri_wr_en, pri_rd_en, pri_rvalid_q, sec_wr_en, sec_rd_en, sec_rvalid_q;
  logic [7:0]          pri_addr, pri_wdata, pri_rdata_q, sec_addr, sec_wdata, sec_rdata_q;
  logic                clk_out_q, jitter_on_rising_q, jitter_on_falling_q, trim_rate_select_q;
  logic                low_jitter_select_q, calib_owner_primary_q, calib_wr_pulse_q;
  logic [1:0]          output_divider_select_q, crystal_drive_level_q, load_cap_select_q;
  rca_pkg::rca_drive_t drive_mode_q;
  rca_pkg::rca_cap_t   cap_mode_q;
  logic signed [7:0]   trim_value_q;
  logic signed [23:0]  trim_x10ppb_q;
  int                  fails = 0;
  int                  checked = 0;

  always #10 clk = ~clk;

  rca_calib_bank rca_calib_bank_inst (.*, .cal_sec(cal[0]), .cal_min(cal[1]), .cal_hour(cal[2]),
    .cal_wday(cal[3]), .cal_mday(cal[4]), .cal_mon(cal[5]));
  rca_host_model pri_host (.clk(clk), .wr_en(pri_wr_en), .rd_en(pri_rd_en), .addr(pri_addr),
    .wdata(pri_wdata), .rdata(pri_rdata_q), .rvalid(pri_rvalid_q));
  rca_host_model sec_host (.clk(clk), .wr_en(sec_wr_en), .rd_en(sec_rd_en), .addr(sec_addr),
    .wdata(sec_wdata), .rdata(sec_rdata_q), .rvalid(sec_rvalid_q));

  // ==========================================================
  // shared tasks
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic rdc(input logic use_sec, input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    logic       ok;
    if (use_sec) begin
      sec_host.rd(a, d, ok);
    end else begin
      pri_host.rd(a, d, ok);
    end
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value %s expected read answer seen none", nm);
      close_out();
    end else begin
      `CHK(nm, e, d)
    end
  endtask : rdc

  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    logic [7:0] adr [11] = '{8'h0c, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b};
    logic [7:0] val [11] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h12, 8'h07, 8'h01, 8'h01, 8'h00};
    for (int i = 0; i < 11; i++) begin
      rdc(1'b1, adr[i], val[i], "reset value");
    end
    `CHK("cap mode", rca_pkg::RCA_CAP_12P5, cap_mode_q)
  endtask : t_reset_values

  task automatic t_secondary_owns();
    sec_host.wr(8'h13, 8'hff);
    rdc(1'b1, 8'h13, 8'hdf, "osc");
    `CHK("rate", 1'b1, trim_rate_select_q)
    `CHK("drive", rca_pkg::RCA_DRIVE_HIGH, drive_mode_q)
    `CHK("cap", rca_pkg::RCA_CAP_UNDEF, cap_mode_q)
    pri_host.wr(8'h13, 8'h00);
    rdc(1'b0, 8'h13, 8'hdf, "osc refused");
    pri_host.wr(8'h12, 8'h55);
    rdc(1'b0, 8'h12, 8'h00, "offset refused");
    sec_host.wr(8'h0c, 8'h03);
    rdc(1'b1, 8'h0c, 8'h03, "clkout");
    `CHK("divider", 2'h3, output_divider_select_q)
    sec_host.wr(8'h14, 8'h80);
    rdc(1'b1, 8'h14, 8'h00, "access refused");
    `CHK("owner", 1'b0, calib_owner_primary_q)
  endtask : t_secondary_owns

  task automatic t_primary_owns();
    pri_host.wr(8'h14, 8'hff);
    rdc(1'b0, 8'h14, 8'h80, "access");
    `CHK("owner", 1'b1, calib_owner_primary_q)
    pri_host.wr(8'h12, 8'h80);
    rdc(1'b1, 8'h12, 8'h80, "offset");
    `CHK("trim fast", 24'(-128 * rca_pkg::STEP_FAST_X10PPB), trim_x10ppb_q)
    `CHK("trim value", 8'h80, trim_value_q)
    sec_host.wr(8'h12, 8'h01);
    rdc(1'b0, 8'h12, 8'h80, "offset refused");
    for (int i = 0; i < 4; i++) begin
      pri_host.wr(8'h13, {4'h0, 2'(i), 2'(i)});
      rdc(1'b0, 8'h13, {4'h0, 2'(i), 2'(i)}, "osc");
      `CHK("drive", (i > 2 ? 2'h2 : 2'(i)), drive_mode_q)
      `CHK("cap", 2'(i), cap_mode_q)
      `CHK("drive field", 2'(i), crystal_drive_level_q)
      `CHK("cap field", 2'(i), load_cap_select_q)
    end
    `CHK("trim normal", 24'(-128 * rca_pkg::STEP_NORMAL_X10PPB), trim_x10ppb_q)
    pri_host.wr(8'h13, 8'h90);
    `CHK("jitter falling", 1'b1, jitter_on_falling_q)
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      div_clk_raw <= ~div_clk_raw;
      @(posedge clk);
      #1;
      `CHK("clk out", ~div_clk_raw, clk_out_q)
    end
    pri_host.wr(8'h13, 8'h10);
    `CHK("jitter rising", 1'b1, jitter_on_rising_q)
    pri_host.wr(8'h13, 8'h00);
    `CHK("jitter", 1'b0, low_jitter_select_q)
  endtask : t_primary_owns

  task automatic t_stamp();
    logic [7:0] adr [8] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h01};
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      for (int j = 0; j < 6; j++) cal[j] <= 8'(k * 8 + j + 1);
      if (k[0]) begin
        sec_host.wr(adr[k], 8'h00);
      end else begin
        pri_host.wr(adr[k], 8'h00);
      end
      for (int j = 0; j < 6; j++) begin
        rdc(1'b0, 8'(8'h15 + j), 8'((k == 7 ? 6 : k) * 8 + j + 1), "stamp");
      end
    end
  endtask : t_stamp

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_reset_values();
    t_secondary_owns();
    t_primary_owns();
    t_stamp();
    close_out();
  end
endmodule : test_rtc_calib_access_timestamp
`default_nettype wire
